// ---- timer_pkg.sv ----
// Purpose : Shared constants and helpers for the processor timer set
// Assumes : Single 250 MHz clock, sleep-clock sources arrive as sampled levels
// Notes   : Dual-timer register map is per channel, channel picked by one address bit
package timer_pkg;

   // ***********************************
   // Clock and sleep-clock figures
   // ***********************************
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned RC_DIV        = 64;
   localparam int unsigned DIV_W         = $clog2(RC_DIV);
   localparam int unsigned CNT_W         = 32;
   localparam int unsigned NUM_CH        = 2;

   // ***********************************
   // Dual-timer register map
   // ***********************************
   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned CH_SEL_BIT    = 5;
   localparam logic [4:0]  OFF_LOAD      = 5'h00;
   localparam logic [4:0]  OFF_VALUE     = 5'h04;
   localparam logic [4:0]  OFF_CTRL      = 5'h08;
   localparam logic [4:0]  OFF_INTCLR    = 5'h0C;
   localparam logic [4:0]  OFF_STATUS    = 5'h10;
   localparam int unsigned CTRL_EN_BIT   = 0;
   localparam int unsigned CTRL_MODE_LSB = 1;
   localparam logic [1:0]  MODE_FREE     = 2'h0;
   localparam logic [1:0]  MODE_PERIODIC = 2'h1;
   localparam logic [1:0]  MODE_ONESHOT  = 2'h2;
   localparam logic [CNT_W-1:0] CNT_MAX  = 32'hFFFFFFFF;
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h00000000;

   // Register offset inside a channel window
   function automatic logic [4:0] reg_off(input logic [ADDR_W-1:0] a);
      return a[4:0];
   endfunction : reg_off

   // True when the address hits a defined dual-timer register
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      logic [4:0] o;
      o = a[4:0];
      return (a[ADDR_W-1:CH_SEL_BIT+1] == '0) &&
             (o == OFF_LOAD || o == OFF_VALUE || o == OFF_CTRL ||
              o == OFF_INTCLR || o == OFF_STATUS);
   endfunction : addr_ok

endpackage : timer_pkg

// ---- chan_if.sv ----
// Purpose : Carries configuration and state between the top and one down-counter
// Assumes : Strobes are single-cycle pulses in the clk_i domain
// Notes   : One instance per dual-timer channel
`timescale 1ns/1ps
interface chan_if;
   import timer_pkg::*;
   logic [CNT_W-1:0] load_val;
   logic [1:0]       mode;
   logic             enable;
   logic             load_stb;
   logic             clr_stb;
   logic [CNT_W-1:0] count;
   logic             irq;

   modport ctl (output load_val, mode, enable, load_stb, clr_stb, input count, irq);
   modport cnt (input load_val, mode, enable, load_stb, clr_stb, output count, irq);
endinterface : chan_if

// ---- down_channel.sv ----
// Purpose : One 32-bit down-counter of the dual timer
// Assumes : Driven through chan_if by the top module
// Notes   : Writing the load value restarts a halted one-shot count
`timescale 1ns/1ps
module down_channel
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Channel link
   chan_if.cnt       ch
);

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             running;
      logic             irq;
   } chan_state_type;

   chan_state_type r, nxt;
   logic           expire;

   assign expire = ch.enable && r.running && !ch.load_stb && (r.count == CNT_ZERO);

   // ***********************************
   // Counting
   // ***********************************
   always_comb begin
      nxt = r;
      if (ch.clr_stb) begin
         nxt.irq = 1'b0;                                  // [RULE_11]
      end
      if (ch.load_stb) begin
         nxt.count   = ch.load_val;
         nxt.running = 1'b1;
      end else if (ch.enable && r.running) begin
         if (r.count == CNT_ZERO) begin
            nxt.irq = 1'b1;                               // [RULE_02] set beats clear
            case (ch.mode)
               MODE_FREE:     nxt.count = CNT_MAX;        // [RULE_10]
               MODE_PERIODIC: nxt.count = ch.load_val;    // [RULE_04]
               MODE_ONESHOT:  nxt.running = 1'b0;         // [RULE_04]
               default:       nxt.count = CNT_MAX;
            endcase
         end else begin
            nxt.count = r.count - 32'h1;                  // [RULE_02]
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign ch.count = r.count;
   assign ch.irq   = r.irq;

   // ***********************************
   // Checks
   // ***********************************
   property p_irq_hold;
      @(posedge clk_i) disable iff (!rst_n_i) ch.irq && !ch.clr_stb |=> ch.irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without clear"); // [RULE_11]

   property p_oneshot_halt;
      @(posedge clk_i) disable iff (!rst_n_i)
         expire && ch.mode == MODE_ONESHOT ##1 !ch.load_stb [*2] |-> ch.count == CNT_ZERO && ch.irq;
   endproperty
   a_oneshot_halt: assert property (p_oneshot_halt) else $error("one-shot kept counting"); // [RULE_04]

   property p_free_wrap;
      @(posedge clk_i) disable iff (!rst_n_i)
         expire && ch.mode == MODE_FREE |=> ch.count == CNT_MAX && ch.irq;
   endproperty
   a_free_wrap: assert property (p_free_wrap) else $error("free-run wrap wrong"); // [RULE_10]

   property p_periodic_reload;
      @(posedge clk_i) disable iff (!rst_n_i)
         expire && ch.mode == MODE_PERIODIC |=> ch.count == $past(ch.load_val) && ch.irq;
   endproperty
   a_periodic_reload: assert property (p_periodic_reload) else $error("periodic reload wrong"); // [RULE_04]

endmodule : down_channel

// ---- processor_timer_set.sv ----
// Purpose : Tick timer, APB dual timer and sleep-clock wake-up timer
// Assumes : All inputs synchronous to clk_i; sleep sources sampled as levels
// Notes   : Tick and wake-up timers are set up through plain ports
//
// What this block does
// [RULE_01] The tick timer counts a programmed 32-bit interval and pulses a tick each time it elapses.
// [RULE_02] The dual timer has two independent 32-bit down-counters, each with its own interrupt on expiry.
// [RULE_03] The dual timer is configured and read as an APB slave.
// [RULE_04] Each dual-timer counter runs free, periodic with reload, or one-shot halting after one expiry.
// [RULE_05] The wake-up timer is a 32-bit down-counter advanced only by the slow sleep clock.
// [RULE_06] Wake-up expiry can raise a processor interrupt, a chip wake-up request, or both.
// [RULE_07] In single-shot use the wake-up timer flags expiry and then stops.
// [RULE_08] In auto-reload use the wake-up timer flags expiry, reloads and counts again at once.
// [RULE_09] Without the crystal, the sleep clock is the 2 MHz RC oscillator divided by 64.
// [RULE_10] A free-running dual-timer counter wraps from zero to all ones and interrupts each wrap.
// [RULE_11] Every timer interrupt stays high until an explicit clear, and set wins over clear. Here a wake_clr_i in a wake-up expiry cycle is ignored.
`timescale 1ns/1ps
module processor_timer_set
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // APB slave, dual timer
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   output logic      [NUM_CH-1:0] dual_irq_o,
   // Tick timer
   input  wire logic              tick_en_i,
   input  wire logic [CNT_W-1:0]  tick_interval_i,
   input  wire logic              tick_clr_i,
   output logic                   tick_o,
   output logic                   tick_irq_o,
   // Sleep clock sources
   input  wire logic              xtal_sel_i,
   input  wire logic              xtal_32k_i,
   input  wire logic              rc_2mhz_i,
   // Wake-up timer
   input  wire logic [CNT_W-1:0]  wake_load_i,
   input  wire logic              wake_start_i,
   input  wire logic              wake_reload_i,
   input  wire logic              wake_irq_en_i,
   input  wire logic              wake_req_en_i,
   input  wire logic              wake_clr_i,
   output logic                   wake_irq_o,
   output logic                   wake_req_o,
   output logic                   wake_running_o,
   output logic      [CNT_W-1:0]  wake_count_o
);

   typedef struct packed {
      logic [NUM_CH-1:0][CNT_W-1:0] load;
      logic [NUM_CH-1:0][1:0]       mode;
      logic [NUM_CH-1:0]            en;
      logic [31:0]                  prdata;
      logic                         slverr;
      logic [CNT_W-1:0]             tick_cnt;
      logic                         tick;
      logic                         tick_irq;
      logic                         rc_prev;
      logic                         xtal_prev;
      logic [DIV_W-1:0]             div_cnt;
      logic                         sleep_tick;
      logic [CNT_W-1:0]             wake_cnt;
      logic                         wake_run;
      logic                         wake_irq;
      logic                         wake_req;
   } top_state_type;

   top_state_type            r, nxt;
   chan_if                   ch [NUM_CH] ();
   logic [NUM_CH-1:0][CNT_W-1:0] cnt_w;
   logic [NUM_CH-1:0]        irq_w;
   logic [NUM_CH-1:0]        load_stb;
   logic [NUM_CH-1:0]        clr_stb;
   logic                     wr_acc;
   logic                     rd_setup;
   logic                     sel_ch;
   logic                     tick_hit;
   logic                     wake_hit;

   // ***********************************
   // APB decode
   // ***********************************
   // Zero wait states; read data is captured in the setup phase so it comes from a flop
   assign pready_o = 1'b1;                                   // [RULE_03]
   assign wr_acc   = psel_i && penable_i && pwrite_i && addr_ok(paddr_i);
   assign rd_setup = psel_i && !penable_i;
   assign sel_ch   = paddr_i[CH_SEL_BIT];

   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
         assign load_stb[g] = wr_acc && (sel_ch == 1'(g)) && (reg_off(paddr_i) == OFF_LOAD);
         assign clr_stb[g]  = wr_acc && (sel_ch == 1'(g)) && (reg_off(paddr_i) == OFF_INTCLR);
         assign ch[g].load_val = r.load[g];
         assign ch[g].mode     = r.mode[g];
         assign ch[g].enable   = r.en[g];
         assign ch[g].load_stb = load_stb[g];
         assign ch[g].clr_stb  = clr_stb[g];
         assign cnt_w[g]       = ch[g].count;
         assign irq_w[g]       = ch[g].irq;
         down_channel u_chan (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .ch      (ch[g])
         );
      end
   endgenerate

   assign tick_hit = tick_en_i && (r.tick_cnt == CNT_ZERO);
   assign wake_hit = r.sleep_tick && r.wake_run && (r.wake_cnt == CNT_ZERO);

   // ***********************************
   // Next state
   // ***********************************
   always_comb begin
      nxt = r;
      // Register writes and reads
      if (wr_acc) begin                                      // [RULE_03]
         case (reg_off(paddr_i))
            OFF_LOAD: nxt.load[sel_ch] = pwdata_i;
            OFF_CTRL: begin
               nxt.en[sel_ch]   = pwdata_i[CTRL_EN_BIT];
               nxt.mode[sel_ch] = pwdata_i[CTRL_MODE_LSB +: 2];
            end
            default: ;
         endcase
      end
      if (rd_setup) begin
         nxt.slverr = !addr_ok(paddr_i);                     // [RULE_03]
         case (reg_off(paddr_i))
            OFF_LOAD:   nxt.prdata = r.load[sel_ch];
            OFF_VALUE:  nxt.prdata = cnt_w[sel_ch];
            OFF_CTRL:   nxt.prdata = {29'h0, r.mode[sel_ch], r.en[sel_ch]};
            OFF_STATUS: nxt.prdata = {31'h0, irq_w[sel_ch]};
            default:    nxt.prdata = 32'h0;
         endcase
         if (!addr_ok(paddr_i)) begin
            nxt.prdata = 32'h0;
         end
      end
      // Tick timer reloads from the live interval, so a new interval applies next period
      nxt.tick = 1'b0;
      if (tick_clr_i) begin
         nxt.tick_irq = 1'b0;                                // [RULE_11]
      end
      if (!tick_en_i) begin
         nxt.tick_cnt = tick_interval_i;
      end else if (tick_hit) begin
         nxt.tick_cnt = tick_interval_i;                     // [RULE_01]
         nxt.tick     = 1'b1;
         nxt.tick_irq = 1'b1;
      end else begin
         nxt.tick_cnt = r.tick_cnt - 32'h1;
      end
      // Sleep clock: one pulse per crystal rising edge or per 64 RC rising edges
      nxt.rc_prev    = rc_2mhz_i;
      nxt.xtal_prev  = xtal_32k_i;
      nxt.sleep_tick = 1'b0;
      if (xtal_sel_i) begin
         nxt.sleep_tick = xtal_32k_i && !r.xtal_prev;
      end else if (rc_2mhz_i && !r.rc_prev) begin
         nxt.div_cnt = r.div_cnt + 1'b1;                     // [RULE_09]
         nxt.sleep_tick = (r.div_cnt == DIV_W'(RC_DIV - 1));
      end
      // Wake-up timer steps only on sleep ticks
      if (wake_clr_i) begin
         nxt.wake_irq = 1'b0;                                // [RULE_11]
         nxt.wake_req = 1'b0;
      end
      if (wake_start_i) begin
         nxt.wake_cnt = wake_load_i;
         nxt.wake_run = 1'b1;
      end else if (wake_hit) begin
         nxt.wake_irq = r.wake_irq || wake_irq_en_i;         // [RULE_06]
         nxt.wake_req = r.wake_req || wake_req_en_i;
         if (wake_reload_i) begin
            nxt.wake_cnt = wake_load_i;                      // [RULE_08]
         end else begin
            nxt.wake_run = 1'b0;                             // [RULE_07]
         end
      end else if (r.sleep_tick && r.wake_run) begin
         nxt.wake_cnt = r.wake_cnt - 32'h1;                  // [RULE_05]
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign prdata_o       = r.prdata;
   assign pslverr_o      = r.slverr;
   assign dual_irq_o     = irq_w;
   assign tick_o         = r.tick;
   assign tick_irq_o     = r.tick_irq;
   assign wake_irq_o     = r.wake_irq;
   assign wake_req_o     = r.wake_req;
   assign wake_running_o = r.wake_run;
   assign wake_count_o   = r.wake_cnt;

   // ***********************************
   // Checks
   // ***********************************
   property p_tick_pulse;
      @(posedge clk_i) disable iff (!rst_n_i)
         tick_hit && !tick_clr_i |=> tick_o && tick_irq_o && r.tick_cnt == $past(tick_interval_i);
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("tick not raised on expiry"); // [RULE_01]

   property p_wake_stop;
      @(posedge clk_i) disable iff (!rst_n_i)
         wake_hit && !wake_reload_i && !wake_start_i |=> !wake_running_o [*3];
   endproperty
   a_wake_stop: assert property (p_wake_stop) else $error("single-shot wake kept running"); // [RULE_07]

   property p_wake_reload;
      @(posedge clk_i) disable iff (!rst_n_i)
         wake_hit && wake_reload_i && !wake_start_i |=>
            wake_running_o && wake_count_o == $past(wake_load_i);
   endproperty
   a_wake_reload: assert property (p_wake_reload) else $error("auto-reload failed"); // [RULE_08]

   property p_wake_flags;
      @(posedge clk_i) disable iff (!rst_n_i)
         wake_hit && wake_irq_en_i && wake_req_en_i && !wake_start_i |=> wake_irq_o && wake_req_o;
   endproperty
   a_wake_flags: assert property (p_wake_flags) else $error("wake expiry not flagged"); // [RULE_06]

   property p_wake_still;
      @(posedge clk_i) disable iff (!rst_n_i)
         !r.sleep_tick && !wake_start_i |=> wake_count_o == $past(wake_count_o);
   endproperty
   a_wake_still: assert property (p_wake_still) else $error("wake moved off sleep tick"); // [RULE_05]

   property p_rc_div;
      @(posedge clk_i) disable iff (!rst_n_i)
         !xtal_sel_i && rc_2mhz_i && !r.rc_prev && r.div_cnt != DIV_W'(RC_DIV - 1) |=> !r.sleep_tick;
   endproperty
   a_rc_div: assert property (p_rc_div) else $error("sleep tick before 64 RC edges"); // [RULE_09]

   property p_apb_err;
      @(posedge clk_i) disable iff (!rst_n_i)
         psel_i && !penable_i && !addr_ok(paddr_i) |=> pslverr_o && prdata_o == 32'h0;
   endproperty
   a_apb_err: assert property (p_apb_err) else $error("unmapped access not refused"); // [RULE_03]

   property p_tick_hold;
      @(posedge clk_i) disable iff (!rst_n_i) tick_irq_o && !tick_clr_i |=> tick_irq_o;
   endproperty
   a_tick_hold: assert property (p_tick_hold) else $error("tick irq dropped"); // [RULE_11]

endmodule : processor_timer_set

// ---- apb_cpu.sv ----
// Purpose : Processor-side APB master model for the dual timer
// Assumes : Called just after a rising edge of clk_i
// Notes   : Optional idle cycles give slow as well as prompt traffic
`timescale 1ns/1ps
module apb_cpu
   import timer_pkg::*;
(
   // Clock
   input  wire logic              clk_i,
   // APB master side
   output logic                   psel_o,
   output logic                   penable_o,
   output logic                   pwrite_o,
   output logic      [ADDR_W-1:0] paddr_o,
   output logic      [31:0]       pwdata_o,
   input  wire logic [31:0]       prdata_i,
   input  wire logic              pready_i,
   input  wire logic              pslverr_i
);
   initial begin
      psel_o    = 1'b0;
      penable_o = 1'b0;
      pwrite_o  = 1'b0;
      paddr_o   = 12'h000;
      pwdata_o  = 32'h00000000;
   end

   // ************************************
   // One transfer, held until pready seen
   // ************************************
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input int idle, output logic [31:0] rd, output logic err);
      repeat (idle) @(posedge clk_i);
      psel_o    <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o  <= wr;
      paddr_o   <= a;
      pwdata_o  <= d;
      @(posedge clk_i);
      penable_o <= 1'b1;
      @(posedge clk_i);
      while (pready_i !== 1'b1) @(posedge clk_i);
      rd = prdata_i;
      err = pslverr_i;
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      // Stale data must not look valid after release
      pwdata_o  <= ~d;
      @(posedge clk_i);
   endtask : xfer
endmodule : apb_cpu

// ---- tb.sv ----
// Purpose : Self-checking bench for the processor timer set
// Assumes : 250 MHz clock, sleep sources made here as sampled levels
// Notes   : Periodic, tick and RC-rate scenarios measure exact periods with one cycle counter
`timescale 1ns/1ps
module tb
   import timer_pkg::*;
;
   logic clk_i = 1'b0, rst_n_i = 1'b0;
   logic psel, penable, pwrite, pready_o, pslverr_o, tick_o, tick_irq_o;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata_o, rd;
   logic [1:0]        dual_irq_o;
   logic tick_en_i = 1'b0, tick_clr_i = 1'b0, xtal_sel_i = 1'b1;
   logic xtal_32k_i = 1'b0, rc_2mhz_i = 1'b0;
   logic wake_start_i = 1'b0, wake_reload_i = 1'b0, wake_irq_en_i = 1'b0, wake_req_en_i = 1'b0;
   logic wake_clr_i = 1'b0, wake_irq_o, wake_req_o, wake_running_o, err;
   logic [CNT_W-1:0]  tick_interval_i = 32'h0, wake_load_i = 32'h0, wake_count_o;
   logic [1:0]        sdiv = 2'h0;
   int bad_count = 0, cmp_count = 0, cyc = 0, t0, i;

   processor_timer_set DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .dual_irq_o(dual_irq_o), .tick_en_i(tick_en_i), .tick_interval_i(tick_interval_i),
      .tick_clr_i(tick_clr_i), .tick_o(tick_o), .tick_irq_o(tick_irq_o),
      .xtal_sel_i(xtal_sel_i), .xtal_32k_i(xtal_32k_i), .rc_2mhz_i(rc_2mhz_i),
      .wake_load_i(wake_load_i), .wake_start_i(wake_start_i), .wake_reload_i(wake_reload_i),
      .wake_irq_en_i(wake_irq_en_i), .wake_req_en_i(wake_req_en_i), .wake_clr_i(wake_clr_i),
      .wake_irq_o(wake_irq_o), .wake_req_o(wake_req_o), .wake_running_o(wake_running_o),
      .wake_count_o(wake_count_o));
   apb_cpu cpu (.clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata_o), .pready_i(pready_o),
      .pslverr_i(pslverr_o));

   // ************************************
   // Clocks, sleep sources and watchdog
   // ************************************
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc        <= cyc + 1;
      sdiv       <= sdiv + 2'h1;
      xtal_32k_i <= sdiv[1];
      rc_2mhz_i  <= ~rc_2mhz_i;
      // Ceiling well above the longest scenario chain
      if (cyc == 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d, 0, rd, err);
   endtask : wr

   // ************************************
   // Scenarios
   // ************************************
   task automatic dual_periodic();
      wr(12'h008, 32'h3);
      wr(12'h000, 32'd20);
      for (i = 0; i < 40 && dual_irq_o[0] !== 1'b1; i++) @(posedge clk_i);
      t0 = cyc;
      wr(12'h00C, 32'h1);
      check(dual_irq_o[0], 1'b0);
      for (i = 0; i < 40 && dual_irq_o[0] !== 1'b1; i++) @(posedge clk_i);
      check(cyc - t0, 21);
      wr(12'h008, 32'h0);
      wr(12'h00C, 32'h1);
   endtask : dual_periodic

   task automatic dual_oneshot_free();
      wr(12'h028, 32'h5);
      wr(12'h020, 32'h4);
      for (i = 0; i < 30 && dual_irq_o[1] !== 1'b1; i++) @(posedge clk_i);
      check(dual_irq_o, 2'b10);
      repeat (20) @(posedge clk_i);
      check(dual_irq_o[1], 1'b1);
      cpu.xfer(1'b0, 12'h030, 32'h0, 3, rd, err);
      check(rd[0], 1'b1);
      cpu.xfer(1'b0, 12'h028, 32'h0, 0, rd, err);
      check(rd, 32'h5);
      wr(12'h02C, 32'h0);
      repeat (20) @(posedge clk_i);
      check(dual_irq_o[1], 1'b0);
      cpu.xfer(1'b0, 12'h024, 32'h0, 0, rd, err);
      check(rd, 32'h0);
      // Load while disabled, so a half-spent count from before cannot expire first
      wr(12'h000, 32'h2);
      wr(12'h008, 32'h1);
      for (i = 0; i < 20 && dual_irq_o[0] !== 1'b1; i++) @(posedge clk_i);
      cpu.xfer(1'b0, 12'h004, 32'h0, 0, rd, err);
      check(rd >= 32'hFFFFFF00, 1'b1);
      wr(12'h008, 32'h0);
      wr(12'h00C, 32'h0);
      check(dual_irq_o[0], 1'b0);
      // Mode code 3 behaves as free-running
      wr(12'h000, 32'h2);
      wr(12'h008, 32'h7);
      for (i = 0; i < 20 && dual_irq_o[0] !== 1'b1; i++) @(posedge clk_i);
      cpu.xfer(1'b0, 12'h004, 32'h0, 0, rd, err);
      check(rd >= 32'hFFFFFF00, 1'b1);
      wr(12'h008, 32'h0);
      wr(12'h00C, 32'h0);
   endtask : dual_oneshot_free

   task automatic dual_refusals();
      cpu.xfer(1'b0, 12'h040, 32'h0, 0, rd, err);
      check(err, 1'b1);
      check(rd, 32'h0);
      cpu.xfer(1'b0, 12'h014, 32'h0, 0, rd, err);
      check(err, 1'b1);
      wr(12'h024, 32'h55);
      cpu.xfer(1'b0, 12'h020, 32'h0, 0, rd, err);
      check(err, 1'b0);
      check(rd, 32'h4);
      cpu.xfer(1'b0, 12'h024, 32'h0, 0, rd, err);
      check(rd, 32'h0);
   endtask : dual_refusals

   task automatic tick_period();
      tick_interval_i <= 32'd6;
      tick_en_i       <= 1'b1;
      for (i = 0; i < 20 && tick_o !== 1'b1; i++) @(posedge clk_i);
      t0 = cyc;
      @(posedge clk_i);
      for (i = 0; i < 20 && tick_o !== 1'b1; i++) @(posedge clk_i);
      check(cyc - t0, 7);
      check(tick_irq_o, 1'b1);
      tick_en_i  <= 1'b0;
      tick_clr_i <= 1'b1;
      @(posedge clk_i);
      tick_clr_i <= 1'b0;
      @(posedge clk_i);
      check(tick_irq_o, 1'b0);
   endtask : tick_period

   task automatic wake_run(input logic rel, input logic req_en, input logic [31:0] ld);
      wake_load_i   <= ld;
      wake_reload_i <= rel;
      wake_irq_en_i <= 1'b1;
      wake_req_en_i <= req_en;
      wake_start_i  <= 1'b1;
      @(posedge clk_i);
      wake_start_i  <= 1'b0;
      // RC sleep ticks are 128 cycles apart, so allow several of them
      for (i = 0; i < 1000 && wake_irq_o !== 1'b1; i++) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      check({wake_irq_o, wake_req_o}, {1'b1, req_en});
      check(wake_running_o, rel);
      wake_clr_i <= 1'b1;
      @(posedge clk_i);
      wake_clr_i <= 1'b0;
      @(posedge clk_i);
      check({wake_irq_o, wake_req_o}, 2'b00);
   endtask : wake_run

   task automatic wake_rc_rate();
      xtal_sel_i <= 1'b0;
      wake_run(1'b1, 1'b0, 32'd5);
      for (i = 0; i < 300 && wake_count_o === 32'd5; i++) @(posedge clk_i);
      t0 = cyc;
      @(posedge clk_i);
      for (i = 0; i < 300 && wake_count_o === 32'd4; i++) @(posedge clk_i);
      check(cyc - t0, 128);
   endtask : wake_rc_rate

   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      check({pready_o, pslverr_o, dual_irq_o, tick_o, wake_irq_o, wake_running_o}, 7'h40);
      dual_periodic();
      dual_oneshot_free();
      dual_refusals();
      tick_period();
      wake_run(1'b0, 1'b1, 32'd3);
      check(wake_count_o, 32'h0);
      wake_run(1'b1, 1'b0, 32'd2);
      wake_rc_rate();
      print_verdict();
   end
endmodule : tb
